// >>> hdl/rip_pkg.sv
// Package for the relay and isolated input port: offsets, widths, reset values
// Assumes an ISA-style byte-wide I/O bus sampled synchronously on mclk
package rip_pkg;
    // Address and data widths of the host I/O bus
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    // Register offsets inside the four-byte window
    localparam logic [1:0] OFS_RELAY_LOW = 2'h0;
    localparam logic [1:0] OFS_RELAY_HIGH = 2'h1;
    localparam logic [1:0] OFS_IN_LOW = 2'h2;
    localparam logic [1:0] OFS_IN_HIGH = 2'h3;
    // Number of low address bits decoded inside the window
    localparam int WIN_BITS = 2;
    // Relay latches start de-energised
    localparam logic [7:0] RELAY_RESET = 8'h00;
    // Value driven on the data bus when not reading
    localparam logic [7:0] IDLE_DATA = 8'h00;

    // One host bus cycle as seen by the port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic ior;
        logic iow;
    } rip_bus_s;

    // Read data answer towards the host
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic rdata_oe;
    } rip_rsp_s;
endpackage

// >>> hdl/rip_decode.sv
// Address decoder for the four-byte window of the port
// Assumes the base comes from switch inputs held steady in operation
`timescale 1ns/1ns
module rip_decode #(
    parameter int ADDR_W = 10
)
(
    // Host address and switch base
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [ADDR_W-1:0] base_sw,
    // Decode result
    output logic hit,
    output logic [1:0] offset
);
    // Compare all bits above the window; low bits of switches ignored
    always_comb
    begin
        hit = (addr[ADDR_W-1:rip_pkg::WIN_BITS] == base_sw[ADDR_W-1:rip_pkg::WIN_BITS]);
        offset = addr[rip_pkg::WIN_BITS-1:0];
    end
endmodule

// >>> hdl/rip_top.sv
// Relay output and isolated input port on a byte-wide host I/O bus
// Assumes bus strobes synchronous to mclk, one access per strobe cycle
`timescale 1ns/1ns
// Operation
// - Four consecutive byte addresses from base
// - Base address comes from switch inputs
// - Offset zero write sets relays 0-7
// - Offset one write sets relays 8-15
// - Offsets zero/one read back relay latches
// - Offset two reads inputs 0-7, write ignored
// - Offset three reads inputs 8-15, write ignored
// - Bit one energises relay, zero releases
// - Bit n drives channel n or n+8
// - Input bit D0 is lowest channel
// - Input high reads one, low zero
module rip_top #(
    parameter int ADDR_W = rip_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Host bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ior,
    input wire logic iow,
    output logic [7:0] rdata,
    output logic rdata_oe,
    // Base address switches
    input wire logic [ADDR_W-1:0] base_sw,
    // Field side
    input wire logic [15:0] isolated_input_channel,
    output logic [15:0] port_channel
);
    // Decoder results
    logic hit;
    logic [1:0] offset;
    // Relay latches, high byte and low byte
    // Pins carry a flop copy so every output is registered
    logic [7:0] relay_lo;
    logic [7:0] relay_hi;
    logic [7:0] next_relay_lo;
    logic [7:0] next_relay_hi;
    // Registered read answer
    logic [7:0] next_rdata;
    logic next_rdata_oe;

    rip_decode #(
        .ADDR_W(ADDR_W)
    )
    u_dec (
        .addr(addr),
        .base_sw(base_sw),
        .hit(hit),
        .offset(offset)
    );

    // Next relay latch values; a whole byte per write, no bit masking
    always_comb
    begin
        next_relay_lo = relay_lo;
        next_relay_hi = relay_hi;
        if (iow && hit)
        begin
            if (offset == rip_pkg::OFS_RELAY_LOW)
            begin
                next_relay_lo = wdata;
            end
            else if (offset == rip_pkg::OFS_RELAY_HIGH)
            begin
                next_relay_hi = wdata;
            end
            // Input offsets ignore writes
            else
            begin
                next_relay_lo = relay_lo;
            end
        end
    end

    // Read mux; answer one cycle after the strobe
    // Reads never disturb the relay latches
    always_comb
    begin
        next_rdata = rip_pkg::IDLE_DATA;
        next_rdata_oe = 1'b0;
        if (ior && hit)
        begin
            next_rdata_oe = 1'b1;
            if (offset == rip_pkg::OFS_RELAY_LOW)
            begin
                next_rdata = relay_lo;
            end
            else if (offset == rip_pkg::OFS_RELAY_HIGH)
            begin
                next_rdata = relay_hi;
            end
            else if (offset == rip_pkg::OFS_IN_LOW)
            begin
                next_rdata = isolated_input_channel[7:0];
            end
            else
            begin
                next_rdata = isolated_input_channel[15:8];
            end
        end
    end

    // Register stage; relay pins load with the latches on the same edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            relay_lo <= rip_pkg::RELAY_RESET;
            relay_hi <= rip_pkg::RELAY_RESET;
            rdata <= rip_pkg::IDLE_DATA;
            rdata_oe <= 1'b0;
            port_channel <= {rip_pkg::RELAY_RESET, rip_pkg::RELAY_RESET};
        end
        else
        begin
            relay_lo <= next_relay_lo;
            relay_hi <= next_relay_hi;
            rdata <= next_rdata;
            rdata_oe <= next_rdata_oe;
            port_channel <= {next_relay_hi, next_relay_lo};
        end
    end

    // Assertions
    // All checks sample on mclk and stay quiet while rst holds, unless reset is the subject
    // low write lands
    AST_WR_LOW: assert property (@(posedge mclk) disable iff (rst)
        iow && hit && offset == 2'h0 |=> port_channel[7:0] == $past(wdata))
        else $error("low relay byte not written");
    AST_WR_HIGH: assert property (@(posedge mclk) disable iff (rst)
        iow && hit && offset == 2'h1 |=> port_channel[15:8] == $past(wdata))
        else $error("high relay byte not written");
    AST_RB: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == 2'h1 |=> rdata_oe && rdata == port_channel[15:8])
        else $error("relay readback wrong");
    AST_IN_LO: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == 2'h2 |=> rdata == $past(isolated_input_channel[7:0]))
        else $error("input low byte wrong");
    AST_IN_HI: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == 2'h3 |=> rdata == $past(isolated_input_channel[15:8]))
        else $error("input high byte wrong");
    AST_MISS: assert property (@(posedge mclk) disable iff (rst)
        !hit || !(ior || iow) |=> !rdata_oe && $stable(port_channel))
        else $error("access outside window acted");
    AST_BASE: assert property (@(posedge mclk) disable iff (rst)
        ior && addr[ADDR_W-1:2] == base_sw[ADDR_W-1:2] |=> rdata_oe)
        else $error("switch base not decoded");
    AST_RST: assert property (@(posedge mclk)
        rst |=> port_channel == 16'h0000)
        else $error("relays not cleared at reset");
    AST_LVL: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == 2'h2 && isolated_input_channel[0] |=> rdata[0])
        else $error("high input not read as one");
    AST_RB_LOW: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == rip_pkg::OFS_RELAY_LOW
        |=> rdata_oe && rdata == port_channel[7:0])
        else $error("low relay readback wrong");
    AST_RO_LOW: assert property (@(posedge mclk) disable iff (rst)
        iow && hit && offset == rip_pkg::OFS_IN_LOW
        |=> $stable(port_channel) && !rdata_oe)
        else $error("write to input low byte acted");
    AST_RO_HIGH: assert property (@(posedge mclk) disable iff (rst)
        iow && hit && offset == rip_pkg::OFS_IN_HIGH
        |=> $stable(port_channel) && !rdata_oe)
        else $error("write to input high byte acted");
    AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !(iow && hit) |=> $stable(port_channel))
        else $error("relays moved without a write");
    AST_LVL_LOW: assert property (@(posedge mclk) disable iff (rst)
        ior && hit && offset == rip_pkg::OFS_IN_LOW && !isolated_input_channel[0]
        |=> !rdata[0])
        else $error("low input not read as zero");
    // answer only after a window read
    AST_OE_CAUSE: assert property (@(posedge mclk) disable iff (rst)
        rdata_oe |-> $past(ior) && $past(hit))
        else $error("read answer without a window read");
    AST_IDLE: assert property (@(posedge mclk) disable iff (rst)
        !rdata_oe |-> rdata == rip_pkg::IDLE_DATA)
        else $error("read data not idle between answers");
    AST_RST_OE: assert property (@(posedge mclk)
        rst |=> !rdata_oe && rdata == rip_pkg::IDLE_DATA)
        else $error("read answer not cleared at reset");
    // Scenarios
    COV_WR: cover property (@(posedge mclk) iow && hit && offset == 2'h0);
    COV_RB: cover property (@(posedge mclk) ior && hit && offset == 2'h1);
    COV_IN: cover property (@(posedge mclk) ior && hit && offset == 2'h3);
    COV_RO: cover property (@(posedge mclk) iow && hit && offset == rip_pkg::OFS_IN_HIGH);
    COV_MISS: cover property (@(posedge mclk) ior && !hit);
endmodule

// >>> verif/rip_host.sv
// Host processor model: byte-wide I/O reads and writes on the port's bus
// Assumes callers enter 1 ns after a rising edge of mclk
`timescale 1ns/1ns
module rip_host (
    // Clock
    input wire logic mclk,
    // Host bus drive
    output rip_pkg::rip_bus_s bus
);
    // Idle bus from time zero
    initial bus = '0;
    task automatic acc(input logic [9:0] a, input logic [7:0] d, input logic wr);
        bus <= '{addr: a, wdata: d, ior: !wr, iow: wr};
        @(posedge mclk);
        #1;
    endtask
    // Released bus: stale address and data inverted so nothing lingers
    task automatic idle();
        bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, ior: 1'b0, iow: 1'b0};
        @(posedge mclk);
        #1;
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the relay and isolated input port
// Assumes rip_top answers reads one cycle after the strobe edge
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("ERROR %0t got %h expected %h", $time, g, e); \
        end \
    end
module tb_top;
    logic mclk, rst;
    rip_pkg::rip_bus_s bus;
    logic [9:0] base_sw, bs;
    logic [15:0] din, port_channel;
    logic [7:0] rdata, lo, hi, seed, exp_b;
    logic rdata_oe;
    logic [7:0] q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    rip_host i_host (.mclk(mclk), .bus(bus));
    rip_top i_dut (.mclk(mclk), .rst(rst), .addr(bus.addr), .wdata(bus.wdata),
        .ior(bus.ior), .iow(bus.iow), .rdata(rdata), .rdata_oe(rdata_oe),
        .base_sw(base_sw), .isolated_input_channel(din), .port_channel(port_channel));
    // Shift register source of random bytes
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Watchdog: run needs a few microseconds
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    // Monitor: every read answer takes the oldest note; looked at mid-cycle
    always @(negedge mclk)
    begin
        if (rdata_oe === 1'b1)
        begin
            if (q.size() == 0)
            begin
                error_cnt++;
                $display("ERROR %0t read answer nobody asked for", $time);
            end
            else
            begin
                exp_b = q.pop_front();
                `CHK(rdata, exp_b)
            end
        end
        else
        begin
            `CHK(rdata, rip_pkg::IDLE_DATA)
        end
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        base_sw = 10'h300;
        din = 16'h0000;
        seed = 8'h3B;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        `CHK(port_channel, 16'h0000)
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            lo = seed;
            seed = lfsr(seed);
            hi = seed;
            // New switch base each pass; low switch bits must be ignored
            base_sw = {lo ^ hi, hi[1:0]};
            bs = {base_sw[9:2], 2'h0};
            din = {~hi, lo ^ 8'h3C};
            i_host.acc(bs, lo, 1'b1);
            i_host.acc(bs + 10'h1, hi, 1'b1);
            `CHK(port_channel, {hi, lo})
            i_host.acc(bs + 10'h2, ~lo, 1'b1);
            i_host.acc(bs + 10'h3, ~hi, 1'b1);
            i_host.acc(bs - 10'h1, ~lo, 1'b1);
            `CHK(port_channel, {hi, lo})
            for (int k = 0; k < 4; k++)
            begin
                q.push_back(k == 0 ? lo : k == 1 ? hi : k == 2 ? din[7:0] : din[15:8]);
                i_host.acc(bs + 10'(k), 8'hFF, 1'b0);
            end
            // Reads just outside the window get no answer
            i_host.acc(bs + 10'h4, 8'hFF, 1'b0);
            i_host.acc(bs - 10'h1, 8'hFF, 1'b0);
            i_host.idle();
            i_host.idle();
        end
        // Mid-run reset with relays set; latches must drop and read back zero
        rst = 1'b1;
        i_host.idle();
        i_host.idle();
        rst = 1'b0;
        `CHK(port_channel, {rip_pkg::RELAY_RESET, rip_pkg::RELAY_RESET})
        for (int k = 0; k < 2; k++)
        begin
            q.push_back(rip_pkg::RELAY_RESET);
            i_host.acc(bs + 10'(k), 8'hFF, 1'b0);
        end
        i_host.idle();
        i_host.idle();
        `CHK(q.size(), 0)
        report_and_stop();
    end
endmodule
